// ===== design/ptp_rx_peer_delay_capture_counters.sv
`timescale 1ns/1ps
// Functional notes
// - with auto-update bit 31 set, each peer-delay request loads seconds, nanoseconds, correction
// - seconds register holds 4-bit read/write value in bits 3:0, reset zero
// - nanoseconds register holds 30-bit value in bits 29:0, reset zero, bit 30 reserved
// - correction high holds bits 63:32; low holds bits 31:16 in its upper half
// - only the nanoseconds part of the correction value is kept
// - checksum-drop tally counts each packet dropped for bad UDP checksum
// - filter-drop tally counts each packet dropped by ingress filtering
// - every such dropped packet is also flagged as a MAC receive error
// - both tallies stop at all ones instead of wrapping
// - host writing zero clears a tally; events since last read are lost
// - registers respond only while the bank-select field chooses bank 1
module ptp_rx_peer_delay_capture_counters (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [8:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [2:0] bank_sel,
	input wire logic pdreq_valid,
	input wire logic [3:0] ingress_seconds,
	input wire logic [29:0] ingress_nanoseconds,
	input wire logic [63:0] correction_value,
	input wire logic checksum_drop,
	input wire logic filter_drop,
	output logic rx_error
);
	// ****************************************
	// state
	// ****************************************
	// timing set, written by the host or loaded from a received request
	logic [3:0] sec_q;
	logic [3:0] sec_d;
	logic [29:0] ns_q;
	logic [29:0] ns_d;
	logic auto_q;
	logic auto_d;
	logic [31:0] corr_hi_q;
	logic [31:0] corr_hi_d;
	logic [15:0] corr_lo_q;
	logic [15:0] corr_lo_d;
	// host read port and error report
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic rx_error_q;
	logic rx_error_d;
	// tally values from the two counter instances
	logic [31:0] chk_count;
	logic [31:0] flt_count;

	// ****************************************
	// bus decode
	// ****************************************
	logic bank_ok;
	logic wr_ok;
	logic rd_ok;
	logic sec_wr;
	logic ns_wr;
	logic corr_hi_wr;
	logic corr_lo_wr;
	logic chk_wr;
	logic flt_wr;

	// port registers share one address space with the general-purpose pin bank
	assign bank_ok = bank_sel == ptp_rx_pdreq_pkg::PORT_BANK;
	assign wr_ok = wr && bank_ok;
	assign rd_ok = rd && bank_ok;
	assign sec_wr = wr_ok && addr == ptp_rx_pdreq_pkg::SECONDS_OFF;
	assign ns_wr = wr_ok && addr == ptp_rx_pdreq_pkg::NANOSECONDS_OFF;
	assign corr_hi_wr = wr_ok && addr == ptp_rx_pdreq_pkg::CORR_HIGH_OFF;
	assign corr_lo_wr = wr_ok && addr == ptp_rx_pdreq_pkg::CORR_LOW_OFF;
	assign chk_wr = wr_ok && addr == ptp_rx_pdreq_pkg::CHKSUM_DROP_OFF;
	assign flt_wr = wr_ok && addr == ptp_rx_pdreq_pkg::FILTER_DROP_OFF;

	// ****************************************
	// capture strobe
	// ****************************************
	logic capture;

	// hardware touches the timing set only while auto-update is on
	assign capture = auto_q && pdreq_valid;

	// ****************************************
	// seconds register
	// ****************************************
	always_comb begin
		sec_d = sec_q;
		if (sec_wr) begin
			sec_d = wdata[ptp_rx_pdreq_pkg::SEC_W-1:0];
		end
		// capture overrides a same-cycle host write so the set stays coherent
		if (capture) begin
			sec_d = ingress_seconds;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sec_q <= ptp_rx_pdreq_pkg::SEC_RST;
		end else begin
			sec_q <= sec_d;
		end
	end

	// ****************************************
	// nanoseconds register
	// ****************************************
	always_comb begin
		ns_d = ns_q;
		if (ns_wr) begin
			ns_d = wdata[ptp_rx_pdreq_pkg::NS_W-1:0];
		end
		// capture overrides a same-cycle host write so the set stays coherent
		if (capture) begin
			ns_d = ingress_nanoseconds;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ns_q <= ptp_rx_pdreq_pkg::NS_RST;
		end else begin
			ns_q <= ns_d;
		end
	end

	// ****************************************
	// auto-update control
	// ****************************************
	always_comb begin
		auto_d = auto_q;
		// writable at any time; software keeps it steady while timing is enabled
		if (ns_wr) begin
			auto_d = wdata[ptp_rx_pdreq_pkg::AUTO_BIT];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			auto_q <= ptp_rx_pdreq_pkg::AUTO_RST;
		end else begin
			auto_q <= auto_d;
		end
	end

	// ****************************************
	// correction high register
	// ****************************************
	always_comb begin
		corr_hi_d = corr_hi_q;
		if (corr_hi_wr) begin
			corr_hi_d = wdata;
		end
		// capture overrides a same-cycle host write so the set stays coherent
		if (capture) begin
			corr_hi_d = correction_value[ptp_rx_pdreq_pkg::CORR_HIGH_LSB +: ptp_rx_pdreq_pkg::CORR_HIGH_W];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			corr_hi_q <= ptp_rx_pdreq_pkg::CORR_HIGH_RST;
		end else begin
			corr_hi_q <= corr_hi_d;
		end
	end

	// ****************************************
	// correction low register
	// ****************************************
	always_comb begin
		corr_lo_d = corr_lo_q;
		if (corr_lo_wr) begin
			corr_lo_d = wdata[ptp_rx_pdreq_pkg::CORR_LOW_LSB +: ptp_rx_pdreq_pkg::CORR_LOW_W];
		end
		// sub-nanosecond fraction below the kept field is dropped
		if (capture) begin
			corr_lo_d = correction_value[ptp_rx_pdreq_pkg::CORR_LOW_LSB +: ptp_rx_pdreq_pkg::CORR_LOW_W];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			corr_lo_q <= ptp_rx_pdreq_pkg::CORR_LOW_RST;
		end else begin
			corr_lo_q <= corr_lo_d;
		end
	end

	// ****************************************
	// checksum drop tally
	// ****************************************
	// a host write loads the tally, so writing zero clears it
	drop_tally checksum_drop_tally (
		.clk(clk),
		.nrst(nrst),
		.event_pulse(checksum_drop),
		.wr_en(chk_wr),
		.wr_data(wdata),
		.count_q(chk_count)
	);

	// ****************************************
	// filter drop tally
	// ****************************************
	drop_tally filter_drop_tally (
		.clk(clk),
		.nrst(nrst),
		.event_pulse(filter_drop),
		.wr_en(flt_wr),
		.wr_data(wdata),
		.count_q(flt_count)
	);

	// ****************************************
	// read views
	// ****************************************
	// reserved bits read as zero
	logic [31:0] sec_view;
	logic [31:0] ns_view;
	logic [31:0] corr_hi_view;
	logic [31:0] corr_lo_view;
	assign sec_view = {28'h0, sec_q};
	assign ns_view = {auto_q, 1'b0, ns_q};
	assign corr_hi_view = corr_hi_q;
	assign corr_lo_view = {corr_lo_q, 16'h0};

	// ****************************************
	// read data
	// ****************************************
	always_comb begin
		rdata_d = ptp_rx_pdreq_pkg::READ_IDLE;
		// an unmapped address or another bank reads as zero
		if (rd_ok) begin
			unique case (addr)
				ptp_rx_pdreq_pkg::SECONDS_OFF: begin
					rdata_d = sec_view;
				end
				ptp_rx_pdreq_pkg::NANOSECONDS_OFF: begin
					rdata_d = ns_view;
				end
				ptp_rx_pdreq_pkg::CORR_HIGH_OFF: begin
					rdata_d = corr_hi_view;
				end
				ptp_rx_pdreq_pkg::CORR_LOW_OFF: begin
					rdata_d = corr_lo_view;
				end
				ptp_rx_pdreq_pkg::CHKSUM_DROP_OFF: begin
					rdata_d = chk_count;
				end
				ptp_rx_pdreq_pkg::FILTER_DROP_OFF: begin
					rdata_d = flt_count;
				end
				default: begin
					rdata_d = ptp_rx_pdreq_pkg::READ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= ptp_rx_pdreq_pkg::READ_IDLE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ****************************************
	// error report
	// ****************************************
	always_comb begin
		rx_error_d = 1'b0;
		// one pulse even when both drop reasons hit the same packet
		if (checksum_drop || filter_drop) begin
			rx_error_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_error_q <= 1'b0;
		end else begin
			rx_error_q <= rx_error_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rdata = rdata_q;
	assign rx_error = rx_error_q;
endmodule

// ===== include/ptp_rx_pdreq_pkg.sv
package ptp_rx_pdreq_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 9;
	localparam logic [8:0] SECONDS_OFF = 9'h178;
	localparam logic [8:0] NANOSECONDS_OFF = 9'h17C;
	localparam logic [8:0] CORR_HIGH_OFF = 9'h180;
	localparam logic [8:0] CORR_LOW_OFF = 9'h184;
	localparam logic [8:0] CHKSUM_DROP_OFF = 9'h188;
	localparam logic [8:0] FILTER_DROP_OFF = 9'h18C;
	localparam logic [2:0] PORT_BANK = 3'h1;

	// ****************************************
	// fields and resets
	// ****************************************
	localparam int SEC_W = 4;
	localparam int NS_W = 30;
	localparam int AUTO_BIT = 31;
	localparam int CORR_LOW_W = 16;
	localparam int CORR_LOW_LSB = 16;
	localparam int CORR_HIGH_W = 32;
	localparam int CORR_HIGH_LSB = 32;
	localparam logic AUTO_RST = 1'b0;
	localparam logic [31:0] READ_IDLE = 32'h0;
	localparam logic [3:0] SEC_RST = 4'h0;
	localparam logic [29:0] NS_RST = 30'h0;
	localparam logic [31:0] CORR_HIGH_RST = 32'h0;
	localparam logic [15:0] CORR_LOW_RST = 16'h0;
	localparam logic [31:0] COUNT_RST = 32'h0;
	localparam logic [31:0] COUNT_MAX = 32'hFFFF_FFFF;
	localparam logic [31:0] CLEAR_VALUE = 32'h0;
endpackage

// ===== design/drop_tally.sv
`timescale 1ns/1ps
// saturating event tally with host write
module drop_tally (
	input wire logic clk,
	input wire logic nrst,
	input wire logic event_pulse,
	input wire logic wr_en,
	input wire logic [31:0] wr_data,
	output logic [31:0] count_q
);
	logic [31:0] count_d;

	always_comb begin
		count_d = count_q;
		if (event_pulse && count_q != ptp_rx_pdreq_pkg::COUNT_MAX) begin
			count_d = count_q + 32'h1;
		end
		// host write wins over a same-cycle event
		if (wr_en) begin
			count_d = wr_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= ptp_rx_pdreq_pkg::COUNT_RST;
		end else begin
			count_q <= count_d;
		end
	end
endmodule

// ===== verif/ptp_rx_asserts.sv
`timescale 1ns/1ps
module ptp_rx_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [8:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic [2:0] bank_sel,
	input wire logic checksum_drop,
	input wire logic filter_drop,
	input wire logic rx_error
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	err_pulse_a: assert property ((checksum_drop || filter_drop) |=> rx_error) else $error("no rx_error");
	err_cause_a: assert property (rx_error |-> $past(checksum_drop || filter_drop)) else $error("bad rx_error");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
	bank_off_a: assert property ((rd && bank_sel != 3'h1) |=> rdata == 32'h0) else $error("bank leak");
	sec_rsvd_a: assert property ((rd && addr == 9'h178) |=> rdata[31:4] == 28'h0) else $error("sec rsvd");
	ns_rsvd_a: assert property ((rd && addr == 9'h17C) |=> !rdata[30]) else $error("ns rsvd");
	low_rsvd_a: assert property ((rd && addr == 9'h184) |=> rdata[15:0] == 16'h0) else $error("low rsvd");
	clear_wins_a: assert property ((wr && bank_sel == 3'h1 && addr == 9'h188 && wdata == 32'h0
		##1 !checksum_drop && !wr
		##1 rd && bank_sel == 3'h1 && addr == 9'h188) |=> rdata == 32'h0) else $error("clear lost");
endmodule

// ===== verif/mac_rx_model.sv
`timescale 1ns/1ps
module mac_rx_model (
	input wire logic clk,
	output logic pdreq_valid,
	output logic [3:0] ingress_seconds,
	output logic [29:0] ingress_nanoseconds,
	output logic [63:0] correction_value,
	output logic checksum_drop,
	output logic filter_drop
);
	initial begin
		{pdreq_valid, checksum_drop, filter_drop} = 3'h0;
		{ingress_seconds, ingress_nanoseconds, correction_value} = 98'h0;
	end
	task pdreq(input logic [3:0] s, input logic [29:0] n, input logic [63:0] c);
		@(posedge clk);
		pdreq_valid <= 1'b1;
		{ingress_seconds, ingress_nanoseconds, correction_value} <= {s, n, c};
		@(posedge clk);
		pdreq_valid <= 1'b0;
		// stale outside the pulse
		{ingress_seconds, ingress_nanoseconds, correction_value} <= ~{s, n, c};
	endtask
	task drop(input logic c, input logic f);
		@(posedge clk);
		{checksum_drop, filter_drop} <= {c, f};
		@(posedge clk);
		{checksum_drop, filter_drop} <= 2'h0;
	endtask
endmodule

// ===== verif/ptp_rx_peer_delay_capture_counters_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; $display("FAIL %0t %h %h", $time, a, b); end end
module ptp_rx_peer_delay_capture_counters_tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [8:0] addr = 9'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [2:0] bank_sel = 3'h1;
	logic [31:0] rdata;
	logic pdreq_valid, checksum_drop, filter_drop, rx_error;
	logic [3:0] ingress_seconds;
	logic [29:0] ingress_nanoseconds;
	logic [63:0] correction_value;
	int bad_count = 0;
	int cmp_count = 0;
	always #10 clk = ~clk;
	mac_rx_model mac_rx_model_inst (.*);
	ptp_rx_peer_delay_capture_counters ptp_rx_peer_delay_capture_counters_inst (.*);
	task wreg(input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rchk(input logic [8:0] a, input logic [31:0] e);
		@(posedge clk);
		{rd, addr} <= {1'b1, a};
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	task end_sim;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task t_reset;
		for (int i = 0; i < 6; i++) rchk(9'h178 + 9'(4 * i), 32'h0);
	endtask
	task t_manual;
		mac_rx_model_inst.pdreq(4'h5, 30'h5, 64'h5);
		rchk(9'h178, 32'h0);
		wreg(9'h178, 32'hFFFF_FFFF);
		rchk(9'h178, 32'h0000_000F);
		wreg(9'h17C, 32'h7FFF_FFFF);
		rchk(9'h17C, 32'h3FFF_FFFF);
		wreg(9'h180, 32'h1357_9BDF);
		rchk(9'h180, 32'h1357_9BDF);
		wreg(9'h184, 32'hFFFF_FFFF);
		rchk(9'h184, 32'hFFFF_0000);
	endtask
	task t_auto;
		wreg(9'h17C, 32'h8000_0000);
		mac_rx_model_inst.pdreq(4'hA, 30'h0123_4567, 64'h89AB_CDEF_FEDC_BA98);
		rchk(9'h178, 32'h0000_000A);
		rchk(9'h17C, 32'h8123_4567);
		rchk(9'h180, 32'h89AB_CDEF);
		rchk(9'h184, 32'hFEDC_0000);
		@(posedge clk) bank_sel <= 3'h2;
		wreg(9'h178, 32'h0);
		rchk(9'h178, 32'h0);
		@(posedge clk) bank_sel <= 3'h1;
		rchk(9'h178, 32'h0000_000A);
		fork
			wreg(9'h178, 32'h0000_0007);
			mac_rx_model_inst.pdreq(4'h3, 30'h0000_0010, 64'h1111_2222_3333_4444);
		join
		rchk(9'h178, 32'h0000_0003);
		rchk(9'h180, 32'h1111_2222);
	endtask
	task t_drop;
		repeat (3) mac_rx_model_inst.drop(1'b1, 1'b1);
		#1 `CHK(rx_error, 1'b1)
		@(posedge clk) #1 `CHK(rx_error, 1'b0)
		rchk(9'h188, 32'h3);
		rchk(9'h18C, 32'h3);
		wreg(9'h18C, 32'hFFFF_FFFE);
		repeat (2) mac_rx_model_inst.drop(1'b0, 1'b1);
		rchk(9'h18C, 32'hFFFF_FFFF);
		fork
			wreg(9'h188, 32'h0);
			mac_rx_model_inst.drop(1'b1, 1'b0);
		join
		rchk(9'h188, 32'h0);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_reset;
		t_manual;
		t_auto;
		t_drop;
		end_sim;
	end
	initial begin
		#50us;
		bad_count++;
		end_sim;
	end
endmodule
bind ptp_rx_peer_delay_capture_counters ptp_rx_chk ptp_rx_chk_inst (.*);
